//--- test/cwdb_switch_model.sv
// behavioural model of the external power switch stage and its fault sensors
`timescale 1ns/1ps
`default_nettype none
module cwdb_switch_model (
	input  wire logic       mclk_i,   // system clock
	input  wire logic       rst_i,    // async reset, active high
	input  wire logic [3:0] inject_i, // fault events commanded by the bench
	input  wire logic       slow_i,   // slow sensor path selected
	output logic      [3:0] fault_o   // fault levels seen by the unit
);
	// ----------------------------------------------------------------
	// sensor pipeline
	// ----------------------------------------------------------------
	logic [3:0] stage [0:3]; // sensor delay line

	// a slow sensor reports four cycles late, so the unit must not rely on early warning
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			stage <= '{default: 4'h0};
		end else begin
			stage[0] <= inject_i;
			for (int i = 1; i < 4; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	// prompt sensing taps the first stage
	assign fault_o = slow_i ? stage[3] : stage[0];
endmodule // cwdb_switch_model
`default_nettype wire

//--- test/test_complementary_waveform_dead_band.sv
// self-checking bench for the complementary waveform unit over its register bus
`timescale 1ns/1ps
`default_nettype none
module test_complementary_waveform_dead_band;
	import cwdb_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and observation signals
	// ----------------------------------------------------------------
	logic        mclk_i         = 1'b0;  // 20 MHz system clock
	logic        rst_i          = 1'b1;  // reset held at start
	logic        fast_tick      = 1'b0;  // fast oscillator tick
	logic        tick_en        = 1'b0;  // runs the fast tick
	logic [6:0]  src_v          = 7'h00; // the seven source levels
	logic [3:0]  inject         = 4'h0;  // fault requests to the switch model
	logic        slow           = 1'b0;  // slow fault sensing
	logic        ce             = 1'b1;  // clock enable of the unit
	logic [3:0]  fault;                  // fault levels into the unit
	logic        drive_a;                // output a
	logic        drive_b;                // output b
	logic [3:0]  s_axi_awaddr   = 4'h0;
	logic        s_axi_awvalid  = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata    = 32'h0;
	logic [3:0]  s_axi_wstrb    = 4'h0;
	logic        s_axi_wvalid   = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready   = 1'b0;
	logic [3:0]  s_axi_araddr   = 4'h0;
	logic        s_axi_arvalid  = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready   = 1'b0;
	int          miscompares    = 0;     // mismatches seen
	int          n_tests        = 0;     // comparisons made
	int          cycles         = 0;     // hang guard
	logic [3:0]  ofs [4] = '{CWDB_OFS_CONTROL_0, CWDB_OFS_CONTROL_1, CWDB_OFS_RISE_DB,
		CWDB_OFS_FALL_DB};

	// clock, half period 25 ns
	initial begin
		forever #25 mclk_i = ~mclk_i;
	end

	// fast tick every other cycle, slower than the system clock on purpose
	always @(posedge mclk_i) begin
		fast_tick <= tick_en & ~fast_tick;
	end

	// ----------------------------------------------------------------
	// design and partner
	// ----------------------------------------------------------------
	cwdb_top uut (
		.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .fast_osc_tick_i(fast_tick),
		.dedicated_waveform_input_pin_i(src_v[0]), .comparator_one_synced_output_i(src_v[1]),
		.comparator_two_synced_output_i(src_v[2]), .pulse_channel_one_output_i(src_v[3]),
		.pulse_channel_two_output_i(src_v[4]), .pulse_channel_three_output_i(src_v[5]),
		.pulse_channel_four_output_i(src_v[6]), .fault_i(fault),
		.drive_output_a_o(drive_a), .drive_output_b_o(drive_b),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	cwdb_switch_model sw (.mclk_i(mclk_i), .rst_i(rst_i), .inject_i(inject), .slow_i(slow),
		.fault_o(fault));

	// ----------------------------------------------------------------
	// helper tasks
	// ----------------------------------------------------------------
	// one comparison, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// write one word, both channels offered together, response compared
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge mclk_i);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge mclk_i);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				done = 1'b1;
				chk({30'h0, s_axi_bresp}, {30'h0, er});
			end
		end
	endtask

	// read one word and compare data and response
	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge mclk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge mclk_i);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				done = 1'b1;
				chk(s_axi_rdata, ed);
				chk({30'h0, s_axi_rresp}, {30'h0, er});
			end
		end
	endtask

	// set source levels and fault requests at one edge
	task automatic drv(input logic [6:0] s, input logic [3:0] f);
		@(posedge mclk_i);
		src_v <= s;
		inject <= f;
	endtask

	// after n edges, compare the pair {a, b}
	task automatic out_is(input int n, input logic [1:0] e);
		repeat (n) @(posedge mclk_i);
		#1;
		chk({30'h0, drive_a, drive_b}, {30'h0, e});
	endtask

	// single closing point of the run
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the sequence needs
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		// reset values, unmapped place, masks
		for (int i = 0; i < 4; i++) rd(ofs[i], 32'h0, CWDB_RESP_OKAY);
		rd(4'h2, 32'h0, CWDB_RESP_SLVERR);
		wr(4'h2, 32'hff, CWDB_RESP_SLVERR);
		wr(CWDB_OFS_CONTROL_0, 32'hff, CWDB_RESP_OKAY);
		rd(CWDB_OFS_CONTROL_0, {24'h0, CWDB_C0_MASK}, CWDB_RESP_OKAY);
		wr(CWDB_OFS_CONTROL_1, 32'hf77, CWDB_RESP_OKAY);
		rd(CWDB_OFS_CONTROL_1, 32'hf77, CWDB_RESP_OKAY);
		wr(CWDB_OFS_RISE_DB, 32'hff, CWDB_RESP_OKAY);
		rd(CWDB_OFS_RISE_DB, 32'h3f, CWDB_RESP_OKAY);
		wr(CWDB_OFS_FALL_DB, 32'hff, CWDB_RESP_OKAY);
		rd(CWDB_OFS_FALL_DB, 32'h3f, CWDB_RESP_OKAY);
		for (int i = 0; i < 4; i++) wr(ofs[i], 32'h0, CWDB_RESP_OKAY);
		out_is(2, 2'b00);
		// enable, both polarities active high, zero dead band
		wr(CWDB_OFS_CONTROL_0, 32'h98, CWDB_RESP_OKAY);
		out_is(3, 2'b01);
		drv(7'h01, 4'h0);
		out_is(2, 2'b10);
		// codes 0 to 6 each select their own source, reserved code 7 stays low
		for (int i = 0; i < 7; i++) begin
			wr(CWDB_OFS_CONTROL_1, i, CWDB_RESP_OKAY);
			drv(7'h01 << i, 4'h0);
			out_is(3, 2'b10);
			drv(~(7'h01 << i), 4'h0);
			out_is(3, 2'b01);
		end
		wr(CWDB_OFS_CONTROL_1, 32'h7, CWDB_RESP_OKAY);
		drv(7'h7f, 4'h0);
		out_is(3, 2'b01);
		// independent rising and falling dead bands
		wr(CWDB_OFS_CONTROL_1, 32'h0, CWDB_RESP_OKAY);
		drv(7'h00, 4'h0);
		wr(CWDB_OFS_RISE_DB, 32'h5, CWDB_RESP_OKAY);
		wr(CWDB_OFS_FALL_DB, 32'h3, CWDB_RESP_OKAY);
		drv(7'h01, 4'h0);
		out_is(5, 2'b00);
		out_is(3, 2'b10);
		drv(7'h00, 4'h0);
		out_is(3, 2'b00);
		out_is(3, 2'b01);
		// dead band timed by the fast tick
		wr(CWDB_OFS_CONTROL_0, 32'h99, CWDB_RESP_OKAY);
		tick_en <= 1'b1;
		drv(7'h01, 4'h0);
		out_is(8, 2'b00);
		out_is(6, 2'b10);
		drv(7'h00, 4'h0);
		out_is(10, 2'b01);
		tick_en <= 1'b0;
		wr(CWDB_OFS_RISE_DB, 32'h0, CWDB_RESP_OKAY);
		wr(CWDB_OFS_FALL_DB, 32'h0, CWDB_RESP_OKAY);
		// both outputs active low
		wr(CWDB_OFS_CONTROL_0, 32'h80, CWDB_RESP_OKAY);
		drv(7'h01, 4'h0);
		out_is(3, 2'b01);
		drv(7'h00, 4'h0);
		out_is(3, 2'b10);
		// shutdown from source 0 only, override a high, no restart
		wr(CWDB_OFS_CONTROL_1, 32'h110, CWDB_RESP_OKAY);
		drv(7'h01, 4'h2);
		out_is(3, 2'b01);
		drv(7'h01, 4'h1);
		out_is(2, 2'b10);
		rd(CWDB_OFS_CONTROL_1, 32'h190, CWDB_RESP_OKAY);
		drv(7'h01, 4'h0);
		out_is(3, 2'b10);
		wr(CWDB_OFS_CONTROL_1, 32'h110, CWDB_RESP_OKAY);
		out_is(3, 2'b01);
		// slow sensor, auto restart, override b high, active high outputs
		wr(CWDB_OFS_CONTROL_0, 32'h98, CWDB_RESP_OKAY);
		wr(CWDB_OFS_CONTROL_1, 32'h460, CWDB_RESP_OKAY);
		slow <= 1'b1;
		drv(7'h01, 4'h4);
		out_is(7, 2'b01);
		drv(7'h01, 4'h0);
		out_is(8, 2'b10);
		// software forced shutdown with both overrides high
		wr(CWDB_OFS_CONTROL_1, 32'hb0, CWDB_RESP_OKAY);
		out_is(2, 2'b11);
		rd(CWDB_OFS_CONTROL_1, 32'hb0, CWDB_RESP_OKAY);
		wr(CWDB_OFS_CONTROL_1, 32'h0, CWDB_RESP_OKAY);
		out_is(3, 2'b10);
		// clock enable low freezes legs and pins, no bus traffic meanwhile
		drv(7'h00, 4'h0);
		ce <= 1'b0;
		out_is(4, 2'b10);
		@(posedge mclk_i);
		ce <= 1'b1;
		out_is(3, 2'b01);
		wr(CWDB_OFS_CONTROL_0, 32'h0, CWDB_RESP_OKAY);
		out_is(2, 2'b00);
		wrap_up();
	end
endmodule // test_complementary_waveform_dead_band
`default_nettype wire

//--- verilog/cwdb_dead_band.sv
// one dead band delay leg: output turns on after its input has been high for count dead band ticks
`timescale 1ns/1ps
`default_nettype none
module cwdb_dead_band
	import cwdb_pkg::*;
#(
	parameter int WIDTH = CWDB_DB_WIDTH
) (
	input  wire logic             mclk_i,   // system clock
	input  wire logic             rst_i,    // async reset
	input  wire logic             ce_i,     // clock enable, low freezes the leg
	input  wire logic             tick_i,   // selected dead band clock tick
	input  wire logic             clr_i,    // force off (disabled)
	input  wire logic             want_i,   // raw request for this output
	input  wire logic [WIDTH-1:0] count_i,  // programmed delay
	output logic                  on_o      // delayed output
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cwdb_db_type      state, next_state;   // leg state
	logic [WIDTH-1:0] cnt, next_cnt;       // elapsed ticks

	// next-state logic: count zero goes straight on
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			CWDB_IDLE_OFF: begin
				if (want_i && !clr_i) begin
					next_cnt = '0;
					if (count_i == '0) begin
						next_state = CWDB_ON;
					end else begin
						next_state = CWDB_WAIT_ON;
					end
				end
			end
			CWDB_WAIT_ON: begin
				if (!want_i || clr_i) begin
					next_state = CWDB_IDLE_OFF; // pulse shorter than dead band is swallowed
				end else if (tick_i) begin
					next_cnt = cnt + 1'b1;
					if (cnt + 1'b1 >= count_i) begin
						next_state = CWDB_ON;
					end
				end
			end
			CWDB_ON: begin
				if (!want_i || clr_i) begin
					next_state = CWDB_IDLE_OFF; // turn-off is immediate
				end
			end
			default: next_state = CWDB_IDLE_OFF;
		endcase
	end

	// registers, held while ce_i is low so a pending dead band is not lost
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= CWDB_IDLE_OFF;
			cnt   <= '0;
		end else if (ce_i) begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	assign on_o = (state == CWDB_ON);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_leg_off_fast: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && (!want_i || clr_i)) |=> !on_o)
		else $error("dead band leg stayed on after request dropped");
	a_leg_zero_db: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && state == CWDB_IDLE_OFF && want_i && !clr_i && count_i == '0) |=> on_o)
		else $error("zero dead band did not turn on next cycle");
endmodule // cwdb_dead_band
`default_nettype wire

//--- verilog/cwdb_pkg.sv
// package: register map, field positions and constants of the complementary waveform unit
`default_nettype none
package cwdb_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] CWDB_OFS_CONTROL_0 = 4'h0; // waveform_control_0
	localparam logic [3:0] CWDB_OFS_CONTROL_1 = 4'h4; // waveform_control_1
	localparam logic [3:0] CWDB_OFS_RISE_DB   = 4'h8; // rising dead band count
	localparam logic [3:0] CWDB_OFS_FALL_DB   = 4'hc; // falling dead band count
	// ----------------------------------------------------------------
	// waveform_control_0 fields
	// ----------------------------------------------------------------
	localparam int CWDB_C0_ENABLE = 7;
	localparam int CWDB_C0_POL_B  = 4;
	localparam int CWDB_C0_POL_A  = 3;
	localparam int CWDB_C0_CLKSEL = 0;
	localparam logic [7:0] CWDB_C0_MASK = 8'h99;
	// ----------------------------------------------------------------
	// waveform_control_1 fields
	// ----------------------------------------------------------------
	localparam int CWDB_C1_SHDN     = 7; // shutdown status, software may force
	localparam int CWDB_C1_RESTART  = 6; // auto restart enable
	localparam int CWDB_C1_OVB_HI   = 5; // override level b
	localparam int CWDB_C1_OVA_HI   = 4; // override level a
	localparam int CWDB_C1_SRC_LO   = 0; // source select [2:0]
	localparam int CWDB_C1_SDEN_LO  = 8; // shutdown source enables [11:8]
	localparam logic [11:0] CWDB_C1_MASK = 12'hff7;
	// ----------------------------------------------------------------
	// source codes and sizes
	// ----------------------------------------------------------------
	localparam logic [2:0] CWDB_SRC_PIN  = 3'h0;
	localparam logic [2:0] CWDB_SRC_RSVD = 3'h7;
	localparam int CWDB_DB_WIDTH  = 6;
	localparam int CWDB_SD_INPUTS = 4;
	localparam logic [1:0] CWDB_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CWDB_RESP_SLVERR = 2'h2;
	// dead band edge counter states
	typedef enum logic [1:0] {
		CWDB_IDLE_OFF,
		CWDB_WAIT_ON,
		CWDB_ON
	} cwdb_db_type;
endpackage
`default_nettype wire

//--- verilog/cwdb_top.sv
// complementary waveform unit with dead band, polarity, auto-shutdown and axi4-lite registers
//
// Notes on behaviour
// - two complementary outputs from selected source
// - delay each turn-on after other's turn-off
// - independent 6-bit rising and falling counters
// - fault ends active drive promptly
// - selectable shutdown sources, restart, override levels
// - one bit selects system or fast clock
// - three-bit field picks one of seven sources
// - both outputs cleared while disabled
// - polarity bit set means active high
// - override levels bypass polarity
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cwdb_top
	import cwdb_pkg::*;
#(
	parameter int DB_WIDTH = CWDB_DB_WIDTH
) (
	input  wire logic        mclk_i,                      // system clock, 20 MHz
	input  wire logic        rst_i,                       // async reset, active high
	input  wire logic        ce_i,                        // clock enable, freezes all state
	input  wire logic        fast_osc_tick_i,             // fast_internal_oscillator tick, sync
	input  wire logic        dedicated_waveform_input_pin_i,
	input  wire logic        comparator_one_synced_output_i,
	input  wire logic        comparator_two_synced_output_i,
	input  wire logic        pulse_channel_one_output_i,
	input  wire logic        pulse_channel_two_output_i,
	input  wire logic        pulse_channel_three_output_i,
	input  wire logic        pulse_channel_four_output_i,
	input  wire logic [3:0]  fault_i,                     // shutdown sources, high = fault
	output logic             drive_output_a_o,
	output logic             drive_output_b_o,
	// axi4-lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]          ctl0, next_ctl0;         // waveform_control_0
	logic [11:0]         ctl1, next_ctl1;         // waveform_control_1 (bit 7 is status)
	logic [DB_WIDTH-1:0] rise_db, next_rise_db;   // rising edge dead band
	logic [DB_WIDTH-1:0] fall_db, next_fall_db;   // falling edge dead band
	logic                aw_held, next_aw_held;   // write address captured
	logic                w_held, next_w_held;     // write data captured
	logic [3:0]          aw_addr, next_aw_addr;
	logic [31:0]         w_data, next_w_data;
	logic [3:0]          w_strb, next_w_strb;
	logic                bvalid, next_bvalid;
	logic [1:0]          bresp, next_bresp;
	logic                rvalid, next_rvalid;
	logic [31:0]         rdata, next_rdata;
	logic [1:0]          rresp, next_rresp;
	logic                out_a, next_out_a;       // registered pin a
	logic                out_b, next_out_b;       // registered pin b
	logic                shdn, next_shdn;         // shutdown latched

	// decoded controls
	logic       enable;
	logic       clk_sel;
	logic [2:0] src_sel;
	logic       src;
	logic       fault_any;
	logic       tick;
	logic       on_a, on_b;
	logic       do_write;
	logic       sw_shdn_set, sw_shdn_clr;

	assign enable  = ctl0[CWDB_C0_ENABLE];
	assign clk_sel = ctl0[CWDB_C0_CLKSEL];
	assign src_sel = ctl1[CWDB_C1_SRC_LO +: 3];

	// ----------------------------------------------------------------
	// source select and clock select
	// ----------------------------------------------------------------
	// source mux, reserved code selects a quiet low input
	always_comb begin
		case (src_sel)
			CWDB_SRC_PIN: src = dedicated_waveform_input_pin_i;
			3'h1:         src = comparator_one_synced_output_i;
			3'h2:         src = comparator_two_synced_output_i;
			3'h3:         src = pulse_channel_one_output_i;
			3'h4:         src = pulse_channel_two_output_i;
			3'h5:         src = pulse_channel_three_output_i;
			3'h6:         src = pulse_channel_four_output_i;
			default:      src = 1'b0; // reserved
		endcase
	end

	// dead band counts either every system cycle or on fast oscillator ticks
	assign tick      = ce_i & (clk_sel ? fast_osc_tick_i : 1'b1);
	assign fault_any = |(fault_i & ctl1[CWDB_C1_SDEN_LO +: CWDB_SD_INPUTS]);

	// ----------------------------------------------------------------
	// dead band legs; each leg freezes itself while ce_i is low
	// ----------------------------------------------------------------
	cwdb_dead_band #(.WIDTH(DB_WIDTH)) u_rise (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.tick_i (tick),
		.clr_i  (!enable | shdn),
		.want_i (src),
		.count_i(rise_db),
		.on_o   (on_a)
	);
	cwdb_dead_band #(.WIDTH(DB_WIDTH)) u_fall (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.ce_i   (ce_i),
		.tick_i (tick),
		.clr_i  (!enable | shdn),
		.want_i (!src),
		.count_i(fall_db),
		.on_o   (on_b)
	);

	// ----------------------------------------------------------------
	// shutdown and output stage
	// ----------------------------------------------------------------
	// shutdown latches on fault; restart only when enabled and fault gone
	always_comb begin
		next_shdn = shdn;
		if (!enable) begin
			next_shdn = 1'b0;
		end else if (fault_any || sw_shdn_set) begin
			next_shdn = 1'b1; // set wins over clear
		end else if (ctl1[CWDB_C1_RESTART] || sw_shdn_clr) begin
			next_shdn = 1'b0;
		end
		// output: override levels unaffected by polarity
		if (!enable) begin
			next_out_a = 1'b0;
			next_out_b = 1'b0;
		end else if (shdn || fault_any) begin
			next_out_a = ctl1[CWDB_C1_OVA_HI];
			next_out_b = ctl1[CWDB_C1_OVB_HI];
		end else begin
			next_out_a = ctl0[CWDB_C0_POL_A] ? on_a : !on_a;
			next_out_b = ctl0[CWDB_C0_POL_B] ? on_b : !on_b;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready  = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rdata   = rdata;
	assign s_axi_rresp   = rresp;
	assign do_write      = aw_held && w_held && !bvalid;
	assign sw_shdn_set   = do_write && aw_addr == CWDB_OFS_CONTROL_1 && w_strb[0]
		&& w_data[CWDB_C1_SHDN];
	assign sw_shdn_clr   = do_write && aw_addr == CWDB_OFS_CONTROL_1 && w_strb[0]
		&& !w_data[CWDB_C1_SHDN];

	// bus and register next values
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		next_ctl0    = ctl0;
		next_ctl1    = ctl1;
		next_rise_db = rise_db;
		next_fall_db = fall_db;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = CWDB_RESP_OKAY;
			// full decode: unaligned addresses get an error, not an alias
			case (aw_addr)
				CWDB_OFS_CONTROL_0: if (w_strb[0]) next_ctl0 = w_data[7:0] & CWDB_C0_MASK;
				CWDB_OFS_CONTROL_1: begin
					if (w_strb[0]) next_ctl1[6:0] = w_data[6:0] & CWDB_C1_MASK[6:0];
					if (w_strb[1]) next_ctl1[11:8] = w_data[11:8];
				end
				CWDB_OFS_RISE_DB: if (w_strb[0]) next_rise_db = w_data[DB_WIDTH-1:0];
				CWDB_OFS_FALL_DB: if (w_strb[0]) next_fall_db = w_data[DB_WIDTH-1:0];
				default: next_bresp = CWDB_RESP_SLVERR;
			endcase
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = CWDB_RESP_OKAY;
			case (s_axi_araddr)
				CWDB_OFS_CONTROL_0: next_rdata = {24'h0, ctl0};
				CWDB_OFS_CONTROL_1: next_rdata = {20'h0, ctl1[11:8], shdn, ctl1[6:0]};
				CWDB_OFS_RISE_DB:   next_rdata = {{(32-DB_WIDTH){1'b0}}, rise_db};
				CWDB_OFS_FALL_DB:   next_rdata = {{(32-DB_WIDTH){1'b0}}, fall_db};
				default: begin
					next_rdata = 32'h0;
					next_rresp = CWDB_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// all registers, frozen while ce_i is low
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl0    <= 8'h00;
			ctl1    <= 12'h000;
			rise_db <= '0;
			fall_db <= '0;
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= 2'h0;
			out_a   <= 1'b0;
			out_b   <= 1'b0;
			shdn    <= 1'b0;
		end else if (ce_i) begin
			ctl0    <= next_ctl0;
			ctl1    <= next_ctl1;
			rise_db <= next_rise_db;
			fall_db <= next_fall_db;
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
			out_a   <= next_out_a;
			out_b   <= next_out_b;
			shdn    <= next_shdn;
		end
	end

	assign drive_output_a_o = out_a;
	assign drive_output_b_o = out_b;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_never_both_on: assert property (@(posedge mclk_i) disable iff (rst_i)
		!(on_a && on_b))
		else $error("both legs active at once");
	a_fault_override: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && enable && fault_any) |=> (out_a == $past(ctl1[CWDB_C1_OVA_HI])))
		else $error("fault did not force override on a");
	a_disable_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && !enable) |=> (!out_a && !out_b))
		else $error("outputs not cleared while disabled");
	a_polarity_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && enable && !shdn && !fault_any)
		|=> (out_a == ($past(ctl0[CWDB_C0_POL_A]) ~^ $past(on_a))))
		else $error("polarity of a not applied");
	a_override_b: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && enable && shdn) |=> (out_b == $past(ctl1[CWDB_C1_OVB_HI])))
		else $error("override b altered");
	a_reserved_src: assert property (@(posedge mclk_i) disable iff (rst_i)
		(src_sel == CWDB_SRC_RSVD) |-> !src)
		else $error("reserved source not quiet");
	a_no_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && enable && shdn && !ctl1[CWDB_C1_RESTART] && !do_write) |=> shdn)
		else $error("shutdown released without restart");
	a_write_resp: assert property (@(posedge mclk_i) disable iff (rst_i)
		(ce_i && do_write) |=> bvalid)
		else $error("write response missing");
endmodule // cwdb_top
`default_nettype wire
